// ---- rtl/bma_pkg.sv ----
/*
 * Shared constants and types for the bus mastership arbiter: bus widths,
 * arbitration and bus-cycle state codes, and the structs carried between
 * the top level and the bus-cycle engine.
 * Assumes one 20 MHz system clock and a synchronous active-low reset.
 */
package bma_pkg;

    // bus geometry
    localparam int ADDR_W = 22;
    localparam int NARROW_ADDR_W = 20;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] NARROW_MASK = 22'h0F_FFFF;

    // clock figures, kept for reference by timing users
    localparam int CLK_PERIOD_NS = 50;

    // arbitration states
    typedef enum logic [1:0] {
        BMA_OWN = 2'b00,
        BMA_GRANT = 2'b01,
        BMA_TAKEN = 2'b10
    } bma_arb_st_t;

    // bus-cycle engine states
    typedef enum logic [1:0] {
        BMA_IDLE = 2'b00,
        BMA_WAIT = 2'b01,
        BMA_END = 2'b10
    } bma_cyc_st_t;

    // one access request from the processor core
    typedef struct packed {
        logic req;
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bma_core_req_t;

    // bus-cycle engine state
    typedef struct packed {
        bma_cyc_st_t st;
        logic as_n;
        logic rw;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic data_oe_n;
        logic [DATA_W-1:0] rdata;
        logic done;
    } bma_cyc_t;

    // arbiter state
    typedef struct packed {
        bma_arb_st_t st;
        logic three_wire;
        logic grant_n;
        logic released;
    } bma_arb_t;

    localparam bma_cyc_t CYC_RST = '{
        st: BMA_IDLE, as_n: 1'b1, rw: 1'b1, addr: '0, wdata: '0,
        data_oe_n: 1'b1, rdata: '0, done: 1'b0};

    localparam bma_arb_t ARB_RST = '{
        st: BMA_OWN, three_wire: 1'b0, grant_n: 1'b1, released: 1'b0};

endpackage

// ---- rtl/bma_cycle.sv ----
/*
 * Bus-cycle engine: runs one non-multiplexed read or write cycle on the
 * external 8-bit data bus, ended by the transfer acknowledge input.
 * Assumes the caller only starts a cycle while the processor owns the bus.
 */
`timescale 1ns/100ps
`default_nettype none

module bma_cycle (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input var bma_pkg::bma_core_req_t core,
    input wire logic transfer_acknowledge_n,
    input wire logic [bma_pkg::DATA_W-1:0] data_in,
    output var bma_pkg::bma_cyc_t cyc
);

    bma_pkg::bma_cyc_t cyc_r;
    bma_pkg::bma_cyc_t cyc_nxt;

    // next-state logic of one bus cycle
    always_comb begin
        cyc_nxt = cyc_r;
        cyc_nxt.done = 1'b0;
        unique case (cyc_r.st)
            bma_pkg::BMA_IDLE: begin
                if (start) begin
                    cyc_nxt.st = bma_pkg::BMA_WAIT;
                    cyc_nxt.as_n = 1'b0;
                    cyc_nxt.rw = ~core.we;
                    cyc_nxt.addr = core.addr;
                    cyc_nxt.wdata = core.wdata;
                    cyc_nxt.data_oe_n = ~core.we;
                end
            end
            bma_pkg::BMA_WAIT: begin
                if (!transfer_acknowledge_n) begin
                    cyc_nxt.st = bma_pkg::BMA_END;
                    cyc_nxt.as_n = 1'b1;
                    cyc_nxt.data_oe_n = 1'b1;
                    cyc_nxt.done = 1'b1;
                    if (cyc_r.rw) begin
                        cyc_nxt.rdata = data_in;
                    end
                end
            end
            bma_pkg::BMA_END: begin
                // wait for the slave to let go of acknowledge
                if (transfer_acknowledge_n) begin
                    cyc_nxt.st = bma_pkg::BMA_IDLE;
                    cyc_nxt.rw = 1'b1;
                end
            end
            default: begin
                cyc_nxt = bma_pkg::CYC_RST;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cyc_r <= bma_pkg::CYC_RST;
        end else begin
            cyc_r <= cyc_nxt;
        end
    end

    assign cyc = cyc_r;

endmodule

`default_nettype wire

// ---- rtl/bma_arbiter.sv ----
/*
 * Bus mastership arbiter of an 8-bit-data-bus processor: request, grant
 * and taken handshake in three-wire form, or request and grant only in
 * the reduced two-wire form, plus the bus drivers that it releases.
 * Assumes all pins are synchronous to CLK and that the configuration
 * strap is steady while RST_N is low.
 */
`timescale 1ns/100ps
`default_nettype none

module bma_arbiter (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CFG_THREE_WIRE,
    input var bma_pkg::bma_core_req_t CORE_REQ,
    output logic CORE_DONE,
    output logic [bma_pkg::DATA_W-1:0] CORE_RDATA,
    input wire logic MASTERSHIP_REQUEST_N,
    input wire logic MASTERSHIP_TAKEN_N,
    output logic MASTERSHIP_GRANT_N,
    output logic [bma_pkg::ADDR_W-1:0] ADDR,
    output logic AS_N,
    output logic RW,
    output logic CTRL_OE_N,
    input wire logic TRANSFER_ACKNOWLEDGE_N,
    input wire logic [bma_pkg::DATA_W-1:0] DATA_IN,
    output logic [bma_pkg::DATA_W-1:0] DATA_OUT,
    output logic DATA_OE_N
);

    bma_pkg::bma_arb_t arb_r;
    bma_pkg::bma_arb_t arb_nxt;
    bma_pkg::bma_cyc_t cyc;
    bma_pkg::bma_core_req_t core_m;
    logic req;
    logic taken;
    logic busy;
    logic start;

    // request is wired-OR outside; taken only exists in three-wire form
    assign req = ~MASTERSHIP_REQUEST_N;
    assign taken = arb_r.three_wire & ~MASTERSHIP_TAKEN_N;
    assign busy = (cyc.st != bma_pkg::BMA_IDLE);

    // new cycles only while we own the bus and nobody asks for it
    assign start = CORE_REQ.req & (arb_r.st == bma_pkg::BMA_OWN)
        & ~req & ~taken & ~busy;

    // reduced form has no upper address pins: drive them low
    always_comb begin
        core_m = CORE_REQ;
        if (!arb_r.three_wire) begin
            core_m.addr = CORE_REQ.addr & bma_pkg::NARROW_MASK;
        end
    end

    // arbitration next state
    always_comb begin
        arb_nxt = arb_r;
        unique case (arb_r.st)
            bma_pkg::BMA_OWN: begin
                arb_nxt.released = 1'b0;
                if (taken) begin
                    arb_nxt.st = bma_pkg::BMA_TAKEN;
                    arb_nxt.grant_n = 1'b1;
                end else if (req) begin
                    arb_nxt.st = bma_pkg::BMA_GRANT;
                    arb_nxt.grant_n = 1'b0;
                end
            end
            bma_pkg::BMA_GRANT: begin
                // let go of the bus only after the running cycle
                if (!busy) begin
                    arb_nxt.released = 1'b1;
                end
                if (taken) begin
                    arb_nxt.st = bma_pkg::BMA_TAKEN;
                    arb_nxt.grant_n = 1'b1;
                    arb_nxt.released = 1'b1;
                end else if (!req) begin
                    arb_nxt.st = bma_pkg::BMA_OWN;
                    arb_nxt.grant_n = 1'b1;
                    arb_nxt.released = 1'b0;
                end
            end
            bma_pkg::BMA_TAKEN: begin
                arb_nxt.grant_n = 1'b1;
                arb_nxt.released = 1'b1;
                if (!taken && !req) begin
                    arb_nxt.st = bma_pkg::BMA_OWN;
                    arb_nxt.released = 1'b0;
                end
            end
            default: begin
                arb_nxt.st = bma_pkg::BMA_OWN;
                arb_nxt.grant_n = 1'b1;
                arb_nxt.released = 1'b0;
            end
        endcase
    end

    // state register; strap caught while reset is held
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            arb_r <= bma_pkg::ARB_RST;
            arb_r.three_wire <= CFG_THREE_WIRE;
        end else begin
            arb_r <= arb_nxt;
        end
    end

    bma_cycle u_cycle (
        .clk(CLK),
        .rst_n(RST_N),
        .start(start),
        .core(core_m),
        .transfer_acknowledge_n(TRANSFER_ACKNOWLEDGE_N),
        .data_in(DATA_IN),
        .cyc(cyc)
    );

    // pins and core answers
    assign MASTERSHIP_GRANT_N = arb_r.grant_n;
    assign ADDR = cyc.addr;
    assign AS_N = cyc.as_n;
    assign RW = cyc.rw;
    assign CTRL_OE_N = arb_r.released;
    assign DATA_OUT = cyc.wdata;
    assign DATA_OE_N = cyc.data_oe_n;
    assign CORE_DONE = cyc.done;
    assign CORE_RDATA = cyc.rdata;

    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // request while owning and idle-taken gives grant next edge
    req_grant_a: assert property (
        (arb_r.st == bma_pkg::BMA_OWN && req && !taken)
        |=> !MASTERSHIP_GRANT_N
    ) else $error("request not answered by grant");

    // drivers stay on while a cycle runs under grant
    hold_cycle_a: assert property (
        busy |-> !CTRL_OE_N
    ) else $error("bus released during a cycle");

    // grant with idle engine releases within two edges
    release_idle_a: assert property (
        (!MASTERSHIP_GRANT_N && !busy) |-> ##[0:2] CTRL_OE_N
    ) else $error("bus not released after cycle end");

    // no strobe follows an edge that saw another master holding the bus
    taken_block_a: assert property (
        taken |=> AS_N
    ) else $error("cycle started while taken");

    // two-wire form never enters the taken state
    two_wire_a: assert property (
        !arb_r.three_wire |-> arb_r.st != bma_pkg::BMA_TAKEN
    ) else $error("taken state in two-wire form");

    // reduced form drives upper address bits low
    narrow_addr_a: assert property (
        (!arb_r.three_wire && !AS_N) |-> ADDR[21:20] == 2'b00
    ) else $error("upper address bits set in reduced form");

    // data drivers only during a write strobe
    data_drive_a: assert property (
        !DATA_OE_N |-> (!AS_N && !RW && !CTRL_OE_N)
    ) else $error("data driven outside write cycle");

    // grant falls one edge after taken is seen under grant
    grant_drop_a: assert property (
        (arb_r.st == bma_pkg::BMA_GRANT && taken) |=> MASTERSHIP_GRANT_N
    ) else $error("grant held after taken");

    // cycles resume only with taken and request both negated
    resume_a: assert property (
        $rose(busy) |-> (!$past(req) && !$past(taken) && !$past(CTRL_OE_N))
    ) else $error("cycle resumed too early");

endmodule

`default_nettype wire

// ---- sim/bma_master_model.sv ----
/* external master: asks, waits for grant and an idle bus, holds it.
   assumes request and taken lines are wired-OR (low wins) by the bench. */
`timescale 1ns/100ps
`default_nettype none
module bma_master_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic three_wire,
    input wire logic want,
    input wire logic grant_n,
    input wire logic as_n,
    input wire logic ack_n,
    input wire logic taken_line_n,
    output logic req_n,
    output logic taken_n
);
    logic ask_r;
    logic own_r;
    logic [2:0] hold_r;
    // two-wire system logic folds taken into request
    assign req_n = ~(ask_r | (own_r & ~three_wire));
    assign taken_n = ~own_r;
    // take only when granted and strobe, ack and taken are idle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ask_r <= 1'b0;
            own_r <= 1'b0;
            hold_r <= 3'h0;
        end else if (own_r) begin
            hold_r <= hold_r + 3'h1;
            own_r <= (hold_r != 3'h5);
        end else if (ask_r && !grant_n && as_n && ack_n
                && taken_line_n) begin
            ask_r <= 1'b0;
            own_r <= 1'b1;
            hold_r <= 3'h0;
        end else if (want) begin
            ask_r <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- sim/test_bus_mastership_arbiter.sv ----
/* random byte accesses while an outside master grabs the bus.
   assumes a slave that acks 0 to 3 cycles after the strobe. */
`timescale 1ns/100ps
`default_nettype none
module test_bus_mastership_arbiter;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg = 1'b1;
    bma_pkg::bma_core_req_t core = '0;
    logic want = 1'b0;
    logic x_tk_n = 1'b1;
    logic [1:0] dly = 2'h0;
    logic [2:0] cnt = 3'h0;
    logic [2:0] own_cnt = 3'h0;
    logic pat = 1'b0;
    int seed = 32'h9a98_39fb;
    int fails = 0;
    int cmp_count = 0;
    logic done, gnt_n, as_n, rw, oe_n, doe_n, ack_n, req_n, m_tk_n;
    logic [7:0] rdata, dout, din;
    logic [21:0] addr;
    bma_arbiter dut_u (.CLK(clk), .RST_N(rst_n), .CFG_THREE_WIRE(cfg),
        .CORE_REQ(core), .CORE_DONE(done), .CORE_RDATA(rdata),
        .MASTERSHIP_REQUEST_N(req_n), .MASTERSHIP_TAKEN_N(m_tk_n & x_tk_n),
        .MASTERSHIP_GRANT_N(gnt_n), .ADDR(addr), .AS_N(as_n), .RW(rw),
        .CTRL_OE_N(oe_n), .TRANSFER_ACKNOWLEDGE_N(ack_n), .DATA_IN(din),
        .DATA_OUT(dout), .DATA_OE_N(doe_n));
    bma_master_model mdl_u (.clk(clk), .rst_n(rst_n), .three_wire(cfg),
        .want(want), .grant_n(gnt_n), .as_n(as_n), .ack_n(ack_n),
        .taken_line_n(m_tk_n & x_tk_n), .req_n(req_n), .taken_n(m_tk_n));
    initial forever #25 clk = ~clk;
    function automatic logic [7:0] exp_rd(input logic [21:0] a);
        return a[7:0] ^ a[21:14] ^ 8'h3c;
    endfunction
    // slave: ack after dly strobed cycles, toggling data when idle
    assign ack_n = (as_n !== 1'b0) || (cnt < {1'b0, dly});
    assign din = ack_n ? {8{pat}} : exp_rd(addr);
    always @(posedge clk) begin
        pat <= ~pat;
        cnt <= (as_n === 1'b0) ? cnt + 3'h1 : 3'h0;
    end
    task automatic chk(input string what, input logic [21:0] exp,
            input logic [21:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bus watch during strobes and while the model holds mastership
    always @(posedge clk) begin
        own_cnt <= (!rst_n || m_tk_n) ? 3'h0 : own_cnt + 3'h1;
        if (as_n === 1'b0) chk("oe in cycle", 22'h0, oe_n);
        if (m_tk_n === 1'b0 && own_cnt >= 3'h1) begin
            chk("as_n taken", 22'h1, as_n);
            if (own_cnt >= 3'h2) chk("oe taken", 22'h1, oe_n);
            if (own_cnt >= 3'h2 && cfg) chk("grant taken", 22'h1, gnt_n);
        end
    end
    task automatic access(input logic we, input logic [21:0] a);
        logic [21:0] ea;
        logic [7:0] d;
        int n;
        ea = cfg ? a : (a & bma_pkg::NARROW_MASK);
        d = 8'($random(seed));
        core <= '{req: 1'b1, we: we, addr: a, wdata: d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (as_n !== 1'b0 && n < 400);
        chk("addr", ea, addr);
        chk("rw", !we, rw);
        if (we) chk("wdata", {d, 1'b0}, {dout, doe_n});
        do begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1 && n < 400);
        // a wait limit that runs out shows up as a missing done pulse
        chk("done", 22'h1, {21'h0, done});
        core.req <= 1'b0;
        if (!we) chk("rdata", exp_rd(ea), rdata);
    endtask
    task automatic run(input logic c);
        rst_n <= 1'b0;
        cfg <= c;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("reset outs", 4'hd, {gnt_n, as_n, oe_n, doe_n});
        // request raised in mid-cycle is granted, bus kept to cycle end
        dly <= 2'h3;
        fork
            access(1'b0, 22'h2a_5a5a);
            begin
                repeat (2) @(posedge clk);
                want <= 1'b1;
                @(posedge clk);
                want <= 1'b0;
                repeat (2) @(posedge clk);
                chk("grant mid", 2'h0, {gnt_n, oe_n});
            end
        join
        // stray taken is ignored in two-wire form
        x_tk_n <= c;
        // one edge with the request low before the next access
        @(posedge clk);
        access(1'b1, 22'h3f_ffff);
        x_tk_n <= 1'b1;
        for (int i = 0; i < 30; i++) begin
            dly <= 2'($random(seed));
            want <= ($random(seed) % 3 == 0);
            @(posedge clk);
            want <= 1'b0;
            access(1'($random(seed)), 22'($random(seed)));
        end
        repeat (10) @(posedge clk);
        $display("test cfg %0d done", c);
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        run(1'b1);
        run(1'b0);
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        wrap_up;
    end
endmodule
`default_nettype wire
